//--- src/orm_device.sv
// device end: register space, address split and big-endian byte lanes
//
// Contract
// - register words travel upper byte first
// - read gives two bytes per clock
// - upper byte strobe high, lower strobe low
// - host writes upper on rise, lower fall
// - address bit zero treated as zero
// - row, column, half-page split of address
// - host derives density from identification fields
// - identification and configuration words decoded by address
// - eighteen die words from 0x08 to 0x2A
// - identification words read-only, writes ignored
// - identification word zero row bit count
// - identification word zero column bit count
// - maker and type codes in low nibble
// - reserved identification bits read zero
// - refresh row count follows row bits
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module orm_device
    import orm_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    orm_link_if.dev link,
    output logic [15:0] configWord0,
    output logic [15:0] configWord1,
    output logic [32:0] refreshRows,
    output logic memReq,
    output logic memWrite,
    output logic [12:0] memRow,
    output logic [5:0] memCol,
    output logic [3:0] memByte,
    output logic [15:0] memWdata,
    input wire logic [15:0] memRdata
);
    logic [2:0] clkSync_q;
    logic [2:0] csSync_q;
    logic [7:0] dqSync0_q;
    logic [7:0] dqSync1_q;
    logic [7:0] dqSync2_q;
    logic clkLvl_q;
    logic csLvl_q;
    logic clkLvl_d;
    logic csLvl_d;
    logic riseEv;
    logic fallEv;
    logic byteEv;
    logic [3:0] slot_q;
    logic [7:0] cmd_q;
    logic [31:0] addr_q;
    logic [7:0] wdHi_q;
    logic [7:0] rdLo_q;
    logic [15:0] cfg0_q;
    logic [15:0] cfg1_q;
    logic [7:0] dqOut_q;
    logic dqOe_q;
    logic strobe_q;
    logic strobeOe_q;
    logic memReq_q;
    logic memWrite_q;
    logic [15:0] memWdata_q;
    logic [32:0] refreshRows_q;
    logic isRead;
    logic isReg;
    logic [15:0] id0;
    logic [15:0] id1;
    logic [15:0] rdWord;

    function automatic logic [15:0] regRead(input logic [31:0] a,
        input logic [15:0] w0, input logic [15:0] w1,
        input logic [15:0] c0, input logic [15:0] c1);
        logic [31:0] wa;
        logic [31:0] dieIdx;
        wa = {a[31:1], 1'b0};
        dieIdx = (wa - ADR_DIE_FIRST) >> 1;
        if (wa == ADR_ID0)
            return w0;
        else if (wa == ADR_ID1)
            return w1;
        else if (wa == ADR_CFG0)
            return c0;
        else if (wa == ADR_CFG1)
            return c1;
        else if (wa >= ADR_DIE_FIRST && wa <= ADR_DIE_LAST)
            return DIE_INFO[dieIdx[4:0]];
        else
            return 16'h0000;
    endfunction

    // constant contents stand in for the nonvolatile identification store
    assign id0 = {3'h0, ROW_BITS_M1,
        COL_BITS_M1, MAKER_CODE};
    assign id1 = {12'h000, TYPE_CODE};

    assign isRead = cmd_q[CMD_READ_POS];
    assign isReg = cmd_q[CMD_REG_POS];
    assign rdWord = isReg ? regRead(addr_q, id0, id1, cfg0_q, cfg1_q)
        : memRdata;

    // link pins come from the host's clock domain
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clkSync_q <= 3'h0;
            csSync_q <= 3'h7;
            dqSync0_q <= 8'h00;
            dqSync1_q <= 8'h00;
            dqSync2_q <= 8'h00;
        end
        else
        begin
            clkSync_q <= {clkSync_q[1:0], link.linkClk};
            csSync_q <= {csSync_q[1:0], link.csN};
            dqSync0_q <= link.dqBus;
            dqSync1_q <= dqSync0_q;
            dqSync2_q <= dqSync1_q;
        end
    end

    assign clkLvl_d = syncLevel(clkSync_q, clkLvl_q);
    assign csLvl_d = syncLevel(csSync_q, csLvl_q);
    assign riseEv = clkLvl_d & ~clkLvl_q;
    assign fallEv = ~clkLvl_d & clkLvl_q;
    // each of the first eight link edges while selected carries one byte
    assign byteEv = (riseEv | fallEv) & ~csLvl_q & (slot_q != SLOT_END);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clkLvl_q <= 1'b0;
            csLvl_q <= 1'b1;
        end
        else
        begin
            clkLvl_q <= clkLvl_d;
            csLvl_q <= csLvl_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || csLvl_q)
            slot_q <= SLOT_CMD;
        else if (byteEv)
            slot_q <= slot_q + 4'h1;
    end

    // command and address capture, upper byte first
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cmd_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            wdHi_q <= 8'h00;
        end
        else if (byteEv)
        begin
            if (slot_q == SLOT_CMD)
                cmd_q <= dqSync2_q;
            if (slot_q >= SLOT_ADDR_FIRST && slot_q <= SLOT_ADDR_LAST)
                addr_q <= {addr_q[23:0], dqSync2_q};
            if (slot_q == SLOT_DATA_HI && !isRead)
                wdHi_q <= dqSync2_q;
        end
    end

    // configuration words are the only writable registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cfg0_q <= CFG0_RESET;
            cfg1_q <= CFG1_RESET;
        end
        else if (byteEv && slot_q == SLOT_DATA_LO && !isRead && isReg)
        begin
            if ({addr_q[31:1], 1'b0} == ADR_CFG0)
                cfg0_q <= {wdHi_q, dqSync2_q};
            else if ({addr_q[31:1], 1'b0} == ADR_CFG1)
                cfg1_q <= {wdHi_q, dqSync2_q};
            // identification and die words ignore writes
        end
    end

    // read drive: strobe copies the link clock, edge aligned with data
    always_ff @(posedge clock)
    begin
        if (sys_rst || csLvl_q)
        begin
            dqOut_q <= 8'h00;
            dqOe_q <= 1'b0;
            strobe_q <= 1'b0;
            strobeOe_q <= 1'b0;
            rdLo_q <= 8'h00;
        end
        else if (byteEv && isRead)
        begin
            if (slot_q == SLOT_DATA_HI)
            begin
                dqOut_q <= rdWord[15:8];
                rdLo_q <= rdWord[7:0];
                strobe_q <= 1'b1;
                dqOe_q <= 1'b1;
                strobeOe_q <= 1'b1;
            end
            else if (slot_q == SLOT_DATA_LO)
            begin
                dqOut_q <= rdLo_q;
                strobe_q <= 1'b0;
            end
        end
    end

    // memory space requests toward the array
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            memReq_q <= 1'b0;
            memWrite_q <= 1'b0;
            memWdata_q <= 16'h0000;
        end
        else
        begin
            memReq_q <= 1'b0;
            if (byteEv && !isReg && isRead && slot_q == SLOT_ADDR_LAST)
            begin
                memReq_q <= 1'b1;
                memWrite_q <= 1'b0;
            end
            else if (byteEv && !isReg && !isRead && slot_q == SLOT_DATA_LO)
            begin
                memReq_q <= 1'b1;
                memWrite_q <= 1'b1;
                memWdata_q <= {wdHi_q, dqSync2_q};
            end
        end
    end

    // rows refreshed per interval follow the reported row bit count
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            refreshRows_q <= 33'h0_0000_0000;
        else
            refreshRows_q <= 33'h0_0000_0001 << (id0[12:8] + 5'h01);
    end

    assign link.dqDevOut = dqOut_q;
    assign link.dqDevOe = dqOe_q;
    assign link.strobeDevOut = strobe_q;
    assign link.strobeDevOe = strobeOe_q;
    assign configWord0 = cfg0_q;
    assign configWord1 = cfg1_q;
    assign refreshRows = refreshRows_q;
    assign memReq = memReq_q;
    assign memWrite = memWrite_q;
    assign memWdata = memWdata_q;
    assign memRow = addr_q[ROW_HI:ROW_LO];
    assign memCol = addr_q[COL_HI:COL_LO];
    assign memByte = {addr_q[HALF_HI:1], 1'b0};
endmodule

//--- src/orm_host.sv
// host end: AHB-Lite command registers driving the octal link
`timescale 1ns/10ps
module orm_host
    import orm_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    orm_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11,
        ST_GAP = 2'b10
    } orm_hstate_t;

    orm_hstate_t state_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic rdMode_q;
    logic regMode_q;
    logic [3:0] div_q;
    logic [3:0] edges_q;
    logic clk_q;
    logic csN_q;
    logic [7:0] dq_q;
    logic dqOe_q;
    logic [2:0] strSync_q;
    logic [7:0] dqSync0_q;
    logic [7:0] dqSync1_q;
    logic [7:0] dqSync2_q;
    logic strLvl_q;
    logic strLvl_d;
    logic [1:0] rdCnt_q;
    logic start;

    // byte for a given link edge, upper byte of every word first
    function automatic logic [7:0] slotByte(input logic [3:0] s,
        input logic rd, input logic rg, input logic [31:0] a,
        input logic [15:0] w);
        case (s)
            SLOT_CMD: slotByte = {rd, rg, 6'h00};
            SLOT_ADDR_FIRST: slotByte = a[31:24];
            4'h3: slotByte = a[23:16];
            4'h4: slotByte = a[15:8];
            SLOT_ADDR_LAST: slotByte = {a[7:1], 1'b0};
            SLOT_DATA_HI: slotByte = w[15:8];
            SLOT_DATA_LO: slotByte = w[7:0];
            default: slotByte = 8'h00;
        endcase
    endfunction

    assign start = wrPend_q && wrAddr_q == HREG_CTRL && hwdata[CTL_START]
        && state_q == ST_IDLE;

    // zero wait state slave
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end
        else if (hready)
        begin
            wrPend_q <= hsel && htrans == HTRANS_NONSEQ && hwrite;
            wrAddr_q <= haddr[7:0];
            if (hsel && htrans == HTRANS_NONSEQ && !hwrite)
            begin
                case (haddr[7:0])
                    HREG_ADDR: hrdata_q <= addr_q;
                    HREG_WDATA: hrdata_q <= {16'h0000, wdata_q};
                    HREG_STATUS: hrdata_q <= {31'h0, state_q != ST_IDLE};
                    HREG_RDATA: hrdata_q <= {16'h0000, rdata_q};
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            addr_q <= 32'h0000_0000;
            wdata_q <= 16'h0000;
            rdMode_q <= 1'b0;
            regMode_q <= 1'b0;
        end
        else if (wrPend_q && state_q == ST_IDLE)
        begin
            if (wrAddr_q == HREG_ADDR)
                addr_q <= hwdata;
            if (wrAddr_q == HREG_WDATA)
                wdata_q <= hwdata[15:0];
            if (start)
            begin
                rdMode_q <= hwdata[CTL_READ];
                regMode_q <= hwdata[CTL_REG];
            end
        end
    end

    // link sequencer; link clock is a divide by 16 of the system clock
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            div_q <= 4'h0;
            edges_q <= 4'h0;
            clk_q <= 1'b0;
            csN_q <= 1'b1;
            dq_q <= 8'h00;
            dqOe_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start)
                    begin
                        state_q <= ST_RUN;
                        csN_q <= 1'b0;
                        div_q <= 4'h0;
                        edges_q <= 4'h0;
                        dq_q <= {hwdata[CTL_READ], hwdata[CTL_REG], 6'h00};
                        dqOe_q <= 1'b1;
                    end
                ST_RUN:
                begin
                    div_q <= div_q + 4'h1;
                    if (div_q == DQ_UPDATE)
                    begin
                        dq_q <= slotByte(edges_q, rdMode_q, regMode_q,
                            addr_q, wdata_q);
                        dqOe_q <= !(rdMode_q && edges_q >= SLOT_DATA_HI);
                    end
                    if (div_q == HALF_PERIOD - 4'h1)
                    begin
                        div_q <= 4'h0;
                        clk_q <= ~clk_q;
                        edges_q <= edges_q + 4'h1;
                        if (edges_q == SLOT_DATA_LO)
                            state_q <= ST_DONE;
                    end
                end
                ST_DONE:
                    if (!rdMode_q || rdCnt_q == 2'h2)
                    begin
                        state_q <= ST_GAP;
                        csN_q <= 1'b1;
                        dqOe_q <= 1'b0;
                        div_q <= 4'h0;
                    end
                ST_GAP:
                begin
                    div_q <= div_q + 4'h1;
                    // deselect long enough for the device to see it
                    if (div_q == HALF_PERIOD - 4'h1)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // read bytes are taken on strobe edges, upper on its rise
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            strSync_q <= 3'h0;
            dqSync0_q <= 8'h00;
            dqSync1_q <= 8'h00;
            dqSync2_q <= 8'h00;
            strLvl_q <= 1'b0;
        end
        else
        begin
            strSync_q <= {strSync_q[1:0], link.strobeBus};
            dqSync0_q <= link.dqBus;
            dqSync1_q <= dqSync0_q;
            dqSync2_q <= dqSync1_q;
            strLvl_q <= strLvl_d;
        end
    end

    assign strLvl_d = syncLevel(strSync_q, strLvl_q);

    always_ff @(posedge clock)
    begin
        if (sys_rst || start)
        begin
            rdata_q <= 16'h0000;
            rdCnt_q <= 2'h0;
        end
        else if (rdMode_q && state_q != ST_IDLE)
        begin
            if (strLvl_d && !strLvl_q)
            begin
                rdata_q[15:8] <= dqSync2_q;
                rdCnt_q <= 2'h1;
            end
            else if (!strLvl_d && strLvl_q && rdCnt_q == 2'h1)
            begin
                rdata_q[7:0] <= dqSync2_q;
                rdCnt_q <= 2'h2;
            end
        end
    end

    assign link.linkClk = clk_q;
    assign link.csN = csN_q;
    assign link.dqHostOut = dq_q;
    assign link.dqHostOe = dqOe_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
endmodule

//--- src/orm_link_if.sv
// link wires between host controller and octal memory device
`timescale 1ns/10ps
interface orm_link_if;
    logic linkClk;
    logic csN;
    logic [7:0] dqHostOut;
    logic dqHostOe;
    logic [7:0] dqDevOut;
    logic dqDevOe;
    logic strobeDevOut;
    logic strobeDevOe;
    logic [7:0] dqBus;
    logic strobeBus;

    // undriven wire reads as low, standing in for a weak pull-down
    assign dqBus = dqDevOe ? dqDevOut : (dqHostOe ? dqHostOut : 8'h00);
    assign strobeBus = strobeDevOe & strobeDevOut;

    modport host (
        output linkClk,
        output csN,
        output dqHostOut,
        output dqHostOe,
        input dqBus,
        input strobeBus
    );
    modport dev (
        input linkClk,
        input csN,
        input dqBus,
        output dqDevOut,
        output dqDevOe,
        output strobeDevOut,
        output strobeDevOe
    );
endinterface

//--- src/orm_pkg.sv
// shared constants and helpers for the octal register-space link
package orm_pkg;
    // link transaction byte slots (two per link clock cycle)
    localparam logic [3:0] SLOT_CMD = 4'h0;
    localparam logic [3:0] SLOT_ADDR_FIRST = 4'h2;
    localparam logic [3:0] SLOT_ADDR_LAST = 4'h5;
    localparam logic [3:0] SLOT_DATA_HI = 4'h6;
    localparam logic [3:0] SLOT_DATA_LO = 4'h7;
    localparam logic [3:0] SLOT_END = 4'h8;
    localparam int CMD_READ_POS = 7;
    localparam int CMD_REG_POS = 6;
    // register space byte addresses
    localparam logic [31:0] ADR_ID0 = 32'h0000_0000;
    localparam logic [31:0] ADR_ID1 = 32'h0000_0002;
    localparam logic [31:0] ADR_CFG0 = 32'h0000_0004;
    localparam logic [31:0] ADR_CFG1 = 32'h0000_0006;
    localparam logic [31:0] ADR_DIE_FIRST = 32'h0000_0008;
    localparam logic [31:0] ADR_DIE_LAST = 32'h0000_002A;
    localparam int DIE_WORDS = 18;
    localparam logic [15:0] DIE_INFO [0:DIE_WORDS-1] = '{default: 16'h0000};
    // identification fields
    localparam logic [4:0] ROW_BITS_M1 = 5'h0C;
    localparam logic [3:0] COL_BITS_M1 = 4'h8;
    localparam logic [3:0] MAKER_CODE = 4'h5; // arbitrary value
    localparam logic [3:0] TYPE_CODE = 4'h3; // arbitrary value
    localparam logic [15:0] CFG0_RESET = 16'h8F2F;
    localparam logic [15:0] CFG1_RESET = 16'h0000;
    // memory address split
    localparam int ROW_HI = 22;
    localparam int ROW_LO = 10;
    localparam int COL_HI = 9;
    localparam int COL_LO = 4;
    localparam int HALF_HI = 3;
    // host side
    localparam logic [3:0] HALF_PERIOD = 4'h8;
    localparam logic [3:0] DQ_UPDATE = 4'h3;
    localparam logic [7:0] HREG_CTRL = 8'h00;
    localparam logic [7:0] HREG_ADDR = 8'h04;
    localparam logic [7:0] HREG_WDATA = 8'h08;
    localparam logic [7:0] HREG_STATUS = 8'h0C;
    localparam logic [7:0] HREG_RDATA = 8'h10;
    localparam int CTL_START = 0;
    localparam int CTL_READ = 1;
    localparam int CTL_REG = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // 3-stage synchroniser value: moves only when stages 2 and 3 agree
    function automatic logic syncLevel(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction
endpackage

//--- tb/octal_ram_register_space_map_tb.sv
// self-checking bench for the octal register-space link
`timescale 1ns/10ps
`define CHK(n, e, v) \
    begin \
        checks++; \
        if ((v) !== (e)) \
        begin \
            num_errors++; \
            $display("mismatch %s exp %h got %h", n, e, v); \
        end \
    end
module octal_ram_register_space_map_tb
    import orm_pkg::*;
;
    logic clock;
    logic sys_rst;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] memRdata;
    logic memReq;
    logic memWrite;
    logic [12:0] memRow;
    logic [5:0] memCol;
    logic [3:0] memByte;
    logic [15:0] memWdata;
    logic [15:0] cfg0;
    logic [15:0] cfg1;
    logic [32:0] rows;
    logic [31:0] q;
    logic [31:0] memAdr;
    logic [15:0] id0;
    logic [15:0] wireWord;
    logic strobeQ = 1'b0;
    int memSeen = 0;
    int num_errors;
    int checks;

    orm_link_if link();
    orm_host i_orm_host (
        .clock(clock), .sys_rst(sys_rst), .link(link), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata)
    );
    orm_device i_orm_device (
        .clock(clock), .sys_rst(sys_rst), .link(link),
        .configWord0(cfg0), .configWord1(cfg1), .refreshRows(rows),
        .memReq(memReq), .memWrite(memWrite), .memRow(memRow),
        .memCol(memCol), .memByte(memByte), .memWdata(memWdata),
        .memRdata(memRdata)
    );
    orm_monitor i_orm_monitor (
        .clock(clock), .sys_rst(sys_rst), .linkClk(link.linkClk),
        .csN(link.csN), .dqHostOe(link.dqHostOe), .dqDevOe(link.dqDevOe),
        .strobeDevOe(link.strobeDevOe), .dqBus(link.dqBus),
        .strobeBus(link.strobeBus)
    );

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // word as seen on the wire: upper byte at strobe rise, lower at fall
    always @(posedge clock)
    begin
        strobeQ <= link.strobeBus;
        if (link.strobeBus === 1'b1 && strobeQ === 1'b0)
            wireWord[15:8] <= link.dqBus;
        if (link.strobeBus === 1'b0 && strobeQ === 1'b1)
            wireWord[7:0] <= link.dqBus;
        if (memReq === 1'b1)
            memSeen <= memSeen + 1;
    end

    task automatic ahb(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // c is {register space, read, start}
    task automatic op(input logic [2:0] c, input logic [31:0] a,
        input logic [15:0] w);
        int n;
        ahb(1'b1, {24'h0, HREG_ADDR}, a);
        ahb(1'b1, {24'h0, HREG_WDATA}, {16'h0, w});
        ahb(1'b1, {24'h0, HREG_CTRL}, {29'h0, c});
        n = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && n < 500)
        begin
            ahb(1'b0, {24'h0, HREG_STATUS}, 32'h0);
            n++;
        end
        `CHK("busy clear", 1'b0, q[0])
        ahb(1'b0, {24'h0, HREG_RDATA}, 32'h0);
    endtask

    task automatic note(input string s);
        $display("test %s finished", s);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clock);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        int i;
        sys_rst = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        memRdata = 16'h0;
        num_errors = 0;
        checks = 0;
        id0 = {3'h0, 5'h0C, 4'h8, MAKER_CODE};
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        `CHK("cfg0 reset", 16'h8F2F, cfg0)
        `CHK("select idle", 1'b1, link.csN)
        op(3'h7, 32'h0, 16'h0);
        `CHK("id0", id0, q[15:0])
        `CHK("id0 wire", id0, wireWord)
        `CHK("rows", 33'h0_0000_2000, rows)
        op(3'h7, 32'h1, 16'h0);
        `CHK("id0 odd", id0, q[15:0])
        op(3'h7, 32'h3, 16'h0);
        `CHK("id1", {12'h0, TYPE_CODE}, q[15:0])
        op(3'h5, 32'h0, 16'hFFFF);
        op(3'h7, 32'h0, 16'h0);
        `CHK("id0 kept", id0, q[15:0])
        note("identification");
        op(3'h7, 32'h4, 16'h0);
        `CHK("cfg0 read", 16'h8F2F, q[15:0])
        op(3'h5, 32'h4, 16'h1234);
        `CHK("cfg0 port", 16'h1234, cfg0)
        op(3'h5, 32'h7, 16'hABCD);
        `CHK("cfg1 port", 16'hABCD, cfg1)
        op(3'h7, 32'h4, 16'h0);
        `CHK("cfg0 back", 16'h1234, q[15:0])
        `CHK("cfg0 wire", 16'h1234, wireWord)
        op(3'h7, 32'h6, 16'h0);
        `CHK("cfg1 back", 16'hABCD, q[15:0])
        note("configuration");
        op(3'h5, 32'h8, 16'hFFFF);
        for (i = 0; i < 18; i++)
        begin
            op(3'h7, 32'h8 + 2 * i, 16'h0);
            `CHK("die word", DIE_INFO[i], q[15:0])
        end
        op(3'h7, 32'h2C, 16'h0);
        `CHK("unmapped word", 16'h0, q[15:0])
        note("die information");
        // odd start address: the host drops bit zero before sending
        memAdr = 32'h0055_AAB7;
        op(3'h1, memAdr, 16'h5A69);
        `CHK("mem pulses", 1, memSeen)
        `CHK("mem write", 1'b1, memWrite)
        `CHK("mem row", memAdr[22:10], memRow)
        `CHK("mem col", memAdr[9:4], memCol)
        `CHK("mem byte", {memAdr[3:1], 1'b0}, memByte)
        `CHK("mem wdata", 16'h5A69, memWdata)
        memRdata <= 16'hC33C;
        op(3'h3, memAdr, 16'h0);
        `CHK("mem read", 16'hC33C, q[15:0])
        `CHK("mem rd flag", 1'b0, memWrite)
        `CHK("mem wire", 16'hC33C, wireWord)
        ahb(1'b0, 32'h20, 32'h0);
        `CHK("host unmapped", 32'h0, q)
        `CHK("hresp", 1'b0, hresp)
        note("memory and host");
        end_of_test();
    end
endmodule

//--- tb/orm_monitor.sv
// link-wire assertions for the octal register-space link
`timescale 1ns/10ps
module orm_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic csN,
    input wire logic dqHostOe,
    input wire logic dqDevOe,
    input wire logic strobeDevOe,
    input wire logic [7:0] dqBus,
    input wire logic strobeBus
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_clock_idle_low:
        assert property (csN |-> !linkClk)
        else $error("link clock high while deselected");
    a_half_period:
        assert property ($changed(linkClk) |=> $stable(linkClk) [*7])
        else $error("link clock half period too short");
    a_setup_at_edge:
        assert property (!csN && dqHostOe && $changed(linkClk)
            |-> $stable(dqBus))
        else $error("host byte moved at a link edge");
    a_no_contention:
        assert property (!(dqHostOe && dqDevOe))
        else $error("host and device drive the bus together");
    a_upper_on_rise:
        assert property ($rose(strobeBus) |-> dqDevOe && !dqHostOe)
        else $error("strobe rose without device driving");
    a_upper_stands:
        assert property (strobeBus && $past(strobeBus) |-> $stable(dqBus))
        else $error("read byte moved while strobe high");
    a_lower_on_fall:
        assert property ($fell(strobeBus) |-> dqDevOe)
        else $error("lower byte not driven after strobe fall");
    a_strobe_read_only:
        assert property (strobeBus |-> !dqHostOe)
        else $error("strobe high while host drives");
    // device only sees the deselect through its synchroniser
    a_device_release:
        assert property (csN [*8] |-> !dqDevOe && !strobeDevOe)
        else $error("device still drives after deselect");
endmodule
